// file: hw/xbar_pkg.sv
// shared constants for the crossbar and memory access arbiter
package xbar_pkg;

  // ----------------------------------------------------------------
  // masters and targets
  // ----------------------------------------------------------------
  localparam int unsigned NUM_MASTERS = 3;        // core, host port, data engine
  localparam int unsigned M_CORE      = 0;        // lowest priority
  localparam int unsigned M_HOST      = 1;        // middle priority
  localparam int unsigned M_DME       = 2;        // highest priority
  localparam int unsigned NUM_TARGETS = 3;
  localparam logic [1:0]  TGT_PERIPH  = 2'h0;     // peripheral subsystem
  localparam logic [1:0]  TGT_INTMEM  = 2'h1;     // internal ram/rom via peripheral port
  localparam logic [1:0]  TGT_EXTMEM  = 2'h2;     // external memory interface

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned PP_DATA_W   = 32;       // peripheral system data port
  localparam int unsigned CORE_DATA_W = 64;       // each processor data port
  localparam int unsigned FETCH_W     = 256;      // instruction fetch port
  localparam int unsigned PAGE_W      = 16;       // 64k byte page number
  localparam int unsigned PAGE_LSB    = 16;       // page field starts here

  // ----------------------------------------------------------------
  // memory controller sources, highest priority first
  // ----------------------------------------------------------------
  localparam int unsigned MC_SRC_PP    = 3;
  localparam int unsigned MC_SRC_DA    = 0;
  localparam int unsigned MC_SRC_DB    = 1;
  localparam int unsigned MC_SRC_FETCH = 2;
  localparam int unsigned MC_MAX_SRV   = 3;

  // ----------------------------------------------------------------
  // clocking and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PERIPH_DIV  = 2;        // core cycles per peripheral cycle
  localparam logic [PAGE_W-1:0] PAGE_RESET = 16'h0000;

  // arbiter state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_OWNED = 2'b10
  } arb_state_t;

endpackage

// file: hw/target_arbiter.sv
// fixed-priority owner arbiter for one crossbar target
`timescale 1ns/10ps
module target_arbiter
  import xbar_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // peripheral clock enable
  input  wire logic                   en,
  // requests and releases, bit per master
  input  wire logic [NUM_MASTERS-1:0] req,
  input  wire logic [NUM_MASTERS-1:0] rel,
  // current owner, one-hot or zero
  output logic      [NUM_MASTERS-1:0] owner
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  arb_state_t             state_reg;   // idle or owned
  arb_state_t             state_next;
  logic [NUM_MASTERS-1:0] owner_reg;   // holder of the target
  logic [NUM_MASTERS-1:0] owner_next;
  logic [NUM_MASTERS-1:0] pick;        // winner among requesters
  logic                   released;    // owner lets go now

  assign pick = req[M_DME]  ? 3'h4 :
                req[M_HOST] ? 3'h2 :
                req[M_CORE] ? 3'h1 : 3'h0;

  assign released = |(owner_reg & rel);
  assign owner    = owner_reg;

  // next state; a grant is only made on a peripheral edge
  always_comb begin
    state_next = state_reg;
    owner_next = owner_reg;
    case (state_reg)
      ST_IDLE: begin
        if (en && (|pick)) begin
          state_next = ST_OWNED;
          owner_next = pick;
        end
      end
      ST_OWNED: begin
        if (released) begin
          state_next = ST_IDLE;
          owner_next = 3'h0;
        end
      end
      default: begin
        state_next = ST_IDLE;
        owner_next = 3'h0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      owner_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      owner_reg <= owner_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_owner_held: assert property (@(posedge clk) disable iff (reset)
    (|owner_reg && !released) |=> (owner_reg == $past(owner_reg)))
    else $error("owner changed without release");
  a_dme_wins: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_IDLE && en && req[M_DME]) |=> owner_reg == 3'h4)
    else $error("data engine lost an idle target");
  a_host_over_core: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_IDLE && en && req[M_HOST] && !req[M_DME]) |=> owner_reg == 3'h2)
    else $error("host did not beat core");
  a_owner_onehot: assert property (@(posedge clk) disable iff (reset)
    $onehot0(owner_reg))
    else $error("more than one owner");
  c_contend: cover property (@(posedge clk) disable iff (reset)
    state_reg == ST_IDLE && en && req[M_DME] && req[M_CORE]);

endmodule // target_arbiter

// file: hw/xbar_arbiter.sv
// crossbar switch with fixed-priority arbitration and memory port arbiter
`timescale 1ns/10ps
module xbar_arbiter
  import xbar_pkg::*;
(
  // clock and reset
  input  wire logic                   CLK_SYS,
  input  wire logic                   RESET,
  // processor core master
  input  wire logic                   CORE_REQ,
  input  wire logic [1:0]             CORE_TGT,
  input  wire logic [ADDR_W-1:0]      CORE_ADDR,
  input  wire logic [PP_DATA_W-1:0]   CORE_WDATA,
  input  wire logic                   CORE_DONE,
  output logic                        CORE_GNT,
  // host port master
  input  wire logic                   HPM_REQ,
  input  wire logic [1:0]             HPM_TGT,
  input  wire logic [ADDR_W-1:0]      HPM_ADDR,
  input  wire logic [PP_DATA_W-1:0]   HPM_WDATA,
  input  wire logic                   HPM_DONE,
  output logic                        HPM_GNT,
  output logic                        HPM_ERR,
  // data movement engine master
  input  wire logic                   DME_REQ,
  input  wire logic [1:0]             DME_TGT,
  input  wire logic [ADDR_W-1:0]      DME_ADDR,
  input  wire logic [PP_DATA_W-1:0]   DME_WDATA,
  input  wire logic                   DME_DONE,
  output logic                        DME_GNT,
  // host page window, set by the core only
  input  wire logic                   HPM_PAGE_LOCK,
  input  wire logic                   CORE_PAGE_WE,
  input  wire logic [PAGE_W-1:0]      CORE_PAGE_VAL,
  output logic      [PAGE_W-1:0]      HPM_PAGE,
  // target path selects, one-hot master per target
  output logic      [NUM_MASTERS-1:0] PERIPH_SEL,
  output logic      [NUM_MASTERS-1:0] INTMEM_SEL,
  output logic      [NUM_MASTERS-1:0] EXTMEM_SEL,
  // peripheral system port towards memory controller
  output logic      [ADDR_W-1:0]      PP_ADDR,
  output logic      [PP_DATA_W-1:0]   PP_WDATA,
  // memory controller core-side requests
  input  wire logic                   MC_DA_REQ,
  input  wire logic                   MC_DB_REQ,
  input  wire logic                   MC_FETCH_REQ,
  output logic      [3:0]             MC_SRV,
  // peripheral clock enable
  output logic                        PERIPH_EN
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one-hot target decode, reused for every master
  function automatic logic [NUM_TARGETS-1:0] tgt_dec(input logic req, input logic [1:0] tgt);
    logic [NUM_TARGETS-1:0] d;
    d = 3'h0;
    if (req && tgt == TGT_PERIPH) d = 3'h1;
    if (req && tgt == TGT_INTMEM) d = 3'h2;
    if (req && tgt == TGT_EXTMEM) d = 3'h4;
    return d;
  endfunction

  // count of set bits in a four-bit request vector
  function automatic logic [2:0] pop4(input logic [3:0] v);
    return {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction

  // ----------------------------------------------------------------
  // peripheral clock enable divider
  // ----------------------------------------------------------------
  logic div_reg;                                 // toggles each core cycle
  logic div_next;
  assign div_next  = ~div_reg;
  assign PERIPH_EN = div_reg;

  // divider register
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      div_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
    end
  end

  // ----------------------------------------------------------------
  // host page window
  // ----------------------------------------------------------------
  logic [PAGE_W-1:0] page_reg;                   // selected 64k page
  logic [PAGE_W-1:0] page_next;
  logic              hpm_in_page;                // host address inside window
  logic              hpm_periph;                 // host aims at peripheral
  logic              hpm_bad;                    // host access refused
  logic              hpm_ok;                     // host access may route

  // only the core port writes the page
  assign page_next   = CORE_PAGE_WE ? CORE_PAGE_VAL : page_reg;
  assign hpm_in_page = HPM_ADDR[PAGE_LSB +: PAGE_W] == page_reg;
  assign hpm_periph  = HPM_TGT == TGT_PERIPH;
  assign hpm_bad     = HPM_REQ && (hpm_periph || (HPM_PAGE_LOCK && !hpm_in_page));
  assign hpm_ok      = HPM_REQ && !hpm_bad;
  assign HPM_PAGE    = page_reg;

  // page register
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      page_reg <= PAGE_RESET;
    end else begin
      page_reg <= page_next;
    end
  end

  // ----------------------------------------------------------------
  // crossbar arbitration, one arbiter per target
  // ----------------------------------------------------------------
  logic [NUM_TARGETS-1:0] core_dec;              // targets core asks for
  logic [NUM_TARGETS-1:0] hpm_dec;               // targets host asks for
  logic [NUM_TARGETS-1:0] dme_dec;               // targets engine asks for
  logic [NUM_MASTERS-1:0] rel;                   // release per master
  logic [NUM_MASTERS-1:0] own_periph;
  logic [NUM_MASTERS-1:0] own_intmem;
  logic [NUM_MASTERS-1:0] own_extmem;

  assign core_dec = tgt_dec(CORE_REQ, CORE_TGT);
  assign hpm_dec  = tgt_dec(hpm_ok, HPM_TGT);
  assign dme_dec  = tgt_dec(DME_REQ, DME_TGT);
  assign rel      = {DME_DONE, HPM_DONE, CORE_DONE};

  // independent arbiter per target runs in parallel
  target_arbiter u_arb_periph (
    .clk   (CLK_SYS),
    .reset (RESET),
    .en    (PERIPH_EN),
    .req   ({dme_dec[0], 1'b0, core_dec[0]}),
    .rel   (rel),
    .owner (own_periph)
  );

  target_arbiter u_arb_intmem (
    .clk   (CLK_SYS),
    .reset (RESET),
    .en    (PERIPH_EN),
    .req   ({dme_dec[1], hpm_dec[1], core_dec[1]}),
    .rel   (rel),
    .owner (own_intmem)
  );

  target_arbiter u_arb_extmem (
    .clk   (CLK_SYS),
    .reset (RESET),
    .en    (PERIPH_EN),
    .req   ({dme_dec[2], hpm_dec[2], core_dec[2]}),
    .rel   (rel),
    .owner (own_extmem)
  );

  // grants are plain ors of registered owners
  assign PERIPH_SEL = own_periph;
  assign INTMEM_SEL = own_intmem;
  assign EXTMEM_SEL = own_extmem;
  assign CORE_GNT   = own_periph[M_CORE] | own_intmem[M_CORE] | own_extmem[M_CORE];
  assign HPM_GNT    = own_intmem[M_HOST] | own_extmem[M_HOST];
  assign DME_GNT    = own_periph[M_DME]  | own_intmem[M_DME]  | own_extmem[M_DME];

  // host refusal pulse, one per peripheral edge while refused
  logic err_reg;
  logic err_next;
  assign err_next = PERIPH_EN && hpm_bad;
  assign HPM_ERR  = err_reg;

  // error register
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
    end
  end

  // ----------------------------------------------------------------
  // peripheral system port into the memory controller
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0]    pp_addr_reg;
  logic [ADDR_W-1:0]    pp_addr_next;
  logic [PP_DATA_W-1:0] pp_wdata_reg;
  logic [PP_DATA_W-1:0] pp_wdata_next;
  logic                 pp_req;                  // engine or host holds the port

  // one 32-bit port shared by engine or host
  assign pp_req        = own_intmem[M_DME] | own_intmem[M_HOST];
  assign pp_addr_next  = own_intmem[M_DME]  ? DME_ADDR  :
                         own_intmem[M_HOST] ? HPM_ADDR  : pp_addr_reg;
  assign pp_wdata_next = own_intmem[M_DME]  ? DME_WDATA :
                         own_intmem[M_HOST] ? HPM_WDATA : pp_wdata_reg;
  assign PP_ADDR       = pp_addr_reg;
  assign PP_WDATA      = pp_wdata_reg;

  // port data registers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pp_addr_reg  <= 32'h0000_0000;
      pp_wdata_reg <= 32'h0000_0000;
    end else begin
      pp_addr_reg  <= pp_addr_next;
      pp_wdata_reg <= pp_wdata_next;
    end
  end

  // ----------------------------------------------------------------
  // memory controller source arbitration, every core cycle
  // ----------------------------------------------------------------
  logic [3:0] mc_req;                            // da, db, fetch, peripheral port
  logic [3:0] mc_srv_reg;
  logic [3:0] mc_srv_next;

  // two data ports, one fetch port and the peripheral system port
  assign mc_req = {pp_req, MC_FETCH_REQ, MC_DB_REQ, MC_DA_REQ};
  // with all four asking, fetch is left out for as long as all four keep asking
  assign mc_srv_next = (pop4(mc_req) > 3'(MC_MAX_SRV)) ? (mc_req & 4'hB) : mc_req;
  assign MC_SRV      = mc_srv_reg;

  // served set updates every core clock
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      mc_srv_reg <= 4'h0;
    end else begin
      mc_srv_reg <= mc_srv_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_host_no_periph: assert property (@(posedge CLK_SYS) disable iff (RESET)
    !own_periph[M_HOST])
    else $error("host reached a peripheral");
  a_mc_three_max: assert property (@(posedge CLK_SYS) disable iff (RESET)
    pop4(mc_srv_reg) <= 3'(MC_MAX_SRV))
    else $error("more than three memory accesses");
  a_page_core_only: assert property (@(posedge CLK_SYS) disable iff (RESET)
    !CORE_PAGE_WE |=> page_reg == $past(page_reg))
    else $error("page changed without core write");
  a_host_out_page: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (PERIPH_EN && HPM_REQ && HPM_PAGE_LOCK && !hpm_in_page) |=> HPM_ERR ##0 !HPM_GNT)
    else $error("out of page host access not refused");
  a_pp_follows: assert property (@(posedge CLK_SYS) disable iff (RESET)
    own_intmem[M_DME] |=> pp_addr_reg == $past(DME_ADDR))
    else $error("port address not from engine");
  c_parallel: cover property (@(posedge CLK_SYS) disable iff (RESET)
    DME_GNT && CORE_GNT);
  c_mc_full: cover property (@(posedge CLK_SYS) disable iff (RESET)
    mc_req == 4'hF);
  c_host_err: cover property (@(posedge CLK_SYS) disable iff (RESET)
    HPM_ERR);

endmodule // xbar_arbiter

// file: verif/bus_master_model.sv
// behavioural bus master standing in for core, host port or data engine
`timescale 1ns/10ps
module bus_master_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // bench controls
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [3:0] hold,
  // crossbar handshake
  input  wire logic       gnt,
  output logic            req,
  output logic            done
);
  logic [3:0] cnt_reg;  // cycles spent owning

  // request stays up until owned and released, or until the bench aborts
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      req     <= 1'b0;
      done    <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (done || abort) begin  // release lands with owner drop
      req  <= 1'b0;
      done <= 1'b0;
    end else if (start && !req) begin
      req     <= 1'b1;
      cnt_reg <= 4'h0;
    end else if (req && gnt) begin  // a slow master holds the target longer
      if (cnt_reg == hold) begin
        done <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule // bus_master_model

// file: verif/testbench.sv
// self-checking bench for the crossbar arbiter
`timescale 1ns/10ps
module testbench;
  import xbar_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;               // core clock
  logic        rst = 1'b1;               // async reset
  logic [2:0]  start = 3'h0, abort = 3'h0; // per master {dme,host,core}
  logic [3:0]  hold = 4'h2;              // owning time of each model
  wire  [2:0]  req, done, gnt;           // master handshakes, one driver per bit
  logic [1:0]  tgt [3] = '{2'h3, 2'h3, 2'h3};
  logic [31:0] addr_h = 32'h0, addr_d = 32'h0, wd_d = 32'h0;
  logic        lock = 1'b0, page_we = 1'b0, err, pen;
  logic [15:0] page_val = 16'h0, page;
  logic [2:0]  mc = 3'h0, psel, isel, esel; // mc is {fetch,db,da}
  logic [3:0]  srv;
  logic [31:0] pp_addr, pp_wdata;
  int          mismatches = 0, n_checks = 0, cycles = 0;

  always #5 clk = ~clk;

  // core address and data never reach the peripheral port, so they stay tied
  xbar_arbiter u_dut (.CLK_SYS(clk), .RESET(rst),
    .CORE_REQ(req[0]), .CORE_TGT(tgt[0]), .CORE_ADDR(32'h0), .CORE_WDATA(32'h0), .CORE_DONE(done[0]),
    .CORE_GNT(gnt[0]), .HPM_REQ(req[1]), .HPM_TGT(tgt[1]), .HPM_ADDR(addr_h), .HPM_WDATA(32'h0),
    .HPM_DONE(done[1]), .HPM_GNT(gnt[1]), .HPM_ERR(err), .DME_REQ(req[2]), .DME_TGT(tgt[2]),
    .DME_ADDR(addr_d), .DME_WDATA(wd_d), .DME_DONE(done[2]), .DME_GNT(gnt[2]), .HPM_PAGE_LOCK(lock),
    .CORE_PAGE_WE(page_we), .CORE_PAGE_VAL(page_val), .HPM_PAGE(page), .PERIPH_SEL(psel),
    .INTMEM_SEL(isel), .EXTMEM_SEL(esel), .PP_ADDR(pp_addr), .PP_WDATA(pp_wdata), .MC_DA_REQ(mc[0]),
    .MC_DB_REQ(mc[1]), .MC_FETCH_REQ(mc[2]), .MC_SRV(srv), .PERIPH_EN(pen));

  // one model per master, index order core, host, engine
  bus_master_model u_m [2:0] (.clk(clk), .reset(rst), .start(start), .abort(abort), .hold(hold),
    .gnt(gnt), .req(req), .done(done));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // pulse start for one cycle; models raise their request on the next edge
  task automatic launch(input logic [2:0] who);
    @(posedge clk) start <= who;
    @(posedge clk) start <= 3'h0;
  endtask

  // bounded wait until every master has let go
  task automatic idle_wait();
    for (int i = 0; i < 40 && req != 3'h0; i++) @(posedge clk);
    check(req, 3'h0, "masters released");
  endtask

  // host request must never be granted and must flag an error
  task automatic refused(input string what);
    int   errs;
    logic g;
    errs = 0;
    g    = 1'b0;
    repeat (10) begin
      @(negedge clk);
      errs = errs + int'(err === 1'b1);
      g    = g | gnt[1];
    end
    check(g, 1'b0, what);
    check(errs > 0, 1'b1, "host error flag");
    @(posedge clk) abort <= 3'b010;
    @(posedge clk) abort <= 3'b000;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    @(negedge clk) check(pen, 1'b0, "enable before first edge");
    check(page, PAGE_RESET, "page reset");
    @(negedge clk) check(pen, 1'b1, "enable first edge");
    @(negedge clk) check(pen, 1'b0, "enable alternates");
    $display("test reset done");
  endtask

  // three masters on three targets at once, engine feeding the memory port
  task automatic t_parallel();
    @(posedge clk) tgt[0] <= TGT_PERIPH;
    tgt[1] <= TGT_EXTMEM;
    tgt[2] <= TGT_INTMEM;
    addr_d <= 32'h0004_1A3C;
    wd_d   <= 32'hC0DE_5A5A;
    hold   <= 4'hC;
    launch(3'b111);
    repeat (3) @(negedge clk);
    check(gnt, 3'b111, "all three granted");
    check(psel, 3'b001, "core on peripherals");
    check(isel, 3'b100, "engine on memory");
    check(esel, 3'b010, "host on external");
    @(posedge clk) mc <= 3'b111;
    repeat (2) @(negedge clk);
    // port copy lands one cycle after the grant
    check(pp_addr, 32'h0004_1A3C, "port addr");
    check(pp_wdata, 32'hC0DE_5A5A, "port data");
    check(srv, 4'hB, "four sources, three served");
    @(posedge clk) mc <= 3'h0;
    idle_wait();
    $display("test parallel done");
  endtask

  // all three fight for one target: engine, then host, then core
  task automatic t_priority();
    logic [2:0] seq [3];
    logic [2:0] last;
    int         k;
    k    = 0;
    last = 3'h0;
    tgt  <= '{TGT_EXTMEM, TGT_EXTMEM, TGT_EXTMEM};
    hold <= 4'h2;
    launch(3'b111);
    for (int i = 0; i < 40 && k < 3; i++) begin
      @(negedge clk);
      if (esel != 3'h0 && esel !== last) begin
        seq[k] = esel;
        last   = esel;
        k++;
      end
    end
    check(seq[0], 3'b100, "first owner");
    check(seq[1], 3'b010, "second owner");
    check(seq[2], 3'b001, "third owner");
    idle_wait();
    $display("test priority done");
  endtask

  task automatic t_host_periph();
    tgt[1] <= TGT_PERIPH;
    launch(3'b010);
    refused("host to peripherals");
    $display("test host path done");
  endtask

  // core moves the host page, then the window is enforced
  task automatic t_page();
    @(posedge clk) page_we <= 1'b1;
    page_val <= 16'hA5C3;
    @(posedge clk) page_we <= 1'b0;
    @(negedge clk) check(page, 16'hA5C3, "page readback");
    @(posedge clk) lock <= 1'b1;
    tgt[1] <= TGT_EXTMEM;
    addr_h <= 32'h0001_0000;
    hold   <= 4'h6;
    launch(3'b010);
    refused("host outside page");
    addr_h <= 32'hA5C3_0040;
    launch(3'b010);
    repeat (3) @(negedge clk);
    check(gnt[1], 1'b1, "host inside page");
    idle_wait();
    lock <= 1'b0;
    $display("test page done");
  endtask

  // memory controller serves every subset of the core-side sources
  task automatic t_memctl();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) mc <= i[2:0];
      @(posedge clk);
      @(negedge clk) check(srv, {1'b0, i[2:0]}, "served set");
    end
    mc <= 3'h0;
    $display("test memory sources done");
  endtask

  // ----------------------------------------------------------------
  // hang guard and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("MISMATCH t=%0t timeout", $time);
      summarize();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_parallel();
    t_priority();
    t_host_periph();
    t_page();
    t_memctl();
    summarize();
  end
endmodule // testbench
